//--- isf_status_flags.sv
// Purpose: Status flags, two-step clears, clock stretch and bus-busy tracking of a
//          multi-master two-wire interface, with an Avalon-MM register slave.
// Assumes: Engine events arrive as one-cycle pulses on clk_sys; bus pins are asynchronous.
// Notes:   Every access is answered with exactly one wait cycle.
//
// What this block does
// - Event flag in top bit of status A; set by events, cleared by status B read, status A read with match, or status A read then data access or control write.
// - Event flag rises on byte done, own address, start sent, master address sent, enabled slave general call, stop flag and error events.
// - Reserved bit 6 of status A and bits 7..5 of status B read zero.
// - Direction bit shows transmit while byte done; clears with byte done.
// - Direction bit also clears on stop, arbitration loss or interface off.
// - Bus-busy sets on start condition, clears on stop condition.
// - Bus-busy keeps tracking while the interface is off.
// - Transmit byte done waits for ack pulse and for post-address event servicing.
// - Receive byte done sets after sent ack pulse when ack enabled.
// - Byte done clears by status A read then data write (transmit) or data read (receive); off clears too.
// - Clock line held low while byte done is set.
// - Address match sets in slave mode on own address or enabled general call; status A read clears.
// - Clock line held low while address match is set.
// - Master bit sets on start request; clears on stop, arbitration loss, off.
// - Start sent flag clears by status A read then data write.
// - Ack failure flag set on missing ack; status B read clears.
// - Stop flag set in slave mode after acknowledge; status B read clears.
// - Arbitration loss sets flag and returns to slave mode.
// - Bus error flag set on misplaced start or stop; status B read clears.
// - No clock stretch while any error flag is set.
// - General call flag set when enabled; stop or off clears it.
// - Interface off clears all flags except bus-busy.
// - Clock also held low while start sent or post-address event pending.
// - All events share one interrupt, gated by enable and global mask.
`timescale 1ns/10ps
`default_nettype none

module isf_status_flags #(
   parameter int ADDR_W = 4
) (
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   // Avalon-MM slave.
   input  wire logic [ADDR_W-1:0] address,
   input  wire logic             read,
   input  wire logic             write,
   input  wire logic [31:0]      writedata,
   input  wire logic [3:0]       byteenable,
   output logic [31:0]           readdata,
   output logic                  waitrequest,
   // Engine side.
   input  wire isf_pkg::isf_evt_t evt,
   input  wire logic [7:0]       rxByte,
   output isf_pkg::isf_ctl_t     ctl,
   output logic [7:0]            txByte,
   output logic                  txLoad,
   output logic                  rxTaken,
   // Bus pins.
   input  wire logic             sclIn,
   input  wire logic             sdaIn,
   output logic                  sclOut,
   output logic                  sclOe_n,
   // Interrupt.
   input  wire logic             globalMask,
   output logic                  irq
);

   // ------------------------------------------------------------------
   // Elaboration check.
   // ------------------------------------------------------------------
   if (ADDR_W < 4) begin : g_chk
      $error("ADDR_W must be at least 4");
   end

   // ------------------------------------------------------------------
   // Register state.
   // ------------------------------------------------------------------
   logic       ackCycle_r;
   logic [7:0] ctl_r;
   logic [7:0] data_r;
   logic       marker_r;
   logic       evf_r, tra_r, busy_r, btf_r, addr_match_flag_r, msl_r, sb_r;
   logic       af_r, stop_seen_flag_r, arb_lost_flag_r, bus_error_flag_r, gen_call_flag_r;
   logic       addrEvt_r;
   logic       btfHeld_r;
   logic       ackSeen_r;
   logic [2:0] sclSync_r, sdaSync_r;

   logic       acc, accRd, accWr;
   logic       hitA, hitB, hitCtl, hitData;
   logic       rdA, rdB, rdData, wrData, wrCtl;
   logic       pe;
   logic       startDet, stopDet;
   logic       seqData;
   logic       setBtf, setTra;
   logic       errAny;
   logic [7:0] statA, statB;

   // Decodes a byte address against one register offset.
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] ofs);
      hit = (a == ADDR_W'(ofs));
   endfunction

   // ------------------------------------------------------------------
   // Bus slave handshake.
   // ------------------------------------------------------------------
   // A request waits one cycle; the answer edge is where side effects occur.
   assign waitrequest = (read | write) & ~ackCycle_r;
   assign acc         = (read | write) & ackCycle_r;
   assign accRd       = acc & read;
   assign accWr       = acc & write & byteenable[0];
   assign hitA        = hit(address, isf_pkg::OFS_STATUS_PRIMARY);
   assign hitB        = hit(address, isf_pkg::OFS_STATUS_ERRORS);
   assign hitCtl      = hit(address, isf_pkg::OFS_CONTROL);
   assign hitData     = hit(address, isf_pkg::OFS_DATA);
   assign rdA         = accRd & hitA;
   assign rdB         = accRd & hitB;
   assign rdData      = accRd & hitData;
   assign wrData      = accWr & hitData;
   assign wrCtl       = accWr & hitCtl;
   assign pe          = ctl_r[isf_pkg::CT_ON];

   // Wait-cycle toggle, cleared at the answer edge.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ackCycle_r <= 1'b0;
      end else begin
         ackCycle_r <= (read | write) & ~ackCycle_r;
      end
   end

   // Read data is loaded during the wait cycle so it stands at the answer edge.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         readdata <= isf_pkg::RST_WORD;
      end else if (read && !ackCycle_r) begin
         if (hitA) begin
            readdata <= {24'h000000, statA};
         end else if (hitB) begin
            readdata <= {24'h000000, statB};
         end else if (hitCtl) begin
            readdata <= {24'h000000, ctl_r};
         end else if (hitData) begin
            readdata <= {24'h000000, rxByte};
         end else begin
            readdata <= isf_pkg::RST_WORD;
         end
      end
   end

   // ------------------------------------------------------------------
   // Control and data registers.
   // ------------------------------------------------------------------
   // Interface off clears every control bit except itself; start clears once sent.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctl_r <= isf_pkg::RST_BYTE;
      end else if (wrCtl) begin
         ctl_r <= writedata[isf_pkg::CT_ON] ? (writedata[7:0] & 8'h3d) : 8'h00;
      end else if (!pe) begin
         ctl_r <= isf_pkg::RST_BYTE;
      end else if (evt.startSent) begin
         ctl_r[isf_pkg::CT_START] <= 1'b0;
      end
   end

   assign ctl.on        = pe;
   assign ctl.genCallEn = ctl_r[isf_pkg::CT_GCEN];
   assign ctl.startReq  = ctl_r[isf_pkg::CT_START];
   assign ctl.ackEn     = ctl_r[isf_pkg::CT_ACK];
   assign ctl.irqEn     = ctl_r[isf_pkg::CT_IRQEN];

   // Transmit byte holding register.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         data_r <= isf_pkg::RST_BYTE;
      end else if (wrData) begin
         data_r <= writedata[7:0];
      end
   end

   // Load and take strobes toward the engine.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         txLoad  <= 1'b0;
         rxTaken <= 1'b0;
      end else begin
         txLoad  <= wrData;
         rxTaken <= rdData;
      end
   end
   assign txByte = data_r;

   // ------------------------------------------------------------------
   // Two-step clear marker.
   // ------------------------------------------------------------------
   // marker arm/cancel
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         marker_r <= 1'b0;
      end else if (acc) begin
         marker_r <= rdA;
      end
   end
   assign seqData = marker_r & (rdData | wrData);

   // ------------------------------------------------------------------
   // Bus pin synchronisers and start/stop detection.
   // ------------------------------------------------------------------
   // Stage 0 feeds only stage 1; stages 1 and 2 feed the detectors.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sclSync_r <= 3'h7;
         sdaSync_r <= 3'h7;
      end else begin
         sclSync_r <= {sclSync_r[1:0], sclIn};
         sdaSync_r <= {sdaSync_r[1:0], sdaIn};
      end
   end
   assign startDet = sclSync_r[1] & sclSync_r[2] & sdaSync_r[2] & ~sdaSync_r[1];
   assign stopDet  = sclSync_r[1] & sclSync_r[2] & ~sdaSync_r[2] & sdaSync_r[1];

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         busy_r <= 1'b0;
      end else if (startDet) begin
         busy_r <= 1'b1;
      end else if (stopDet) begin
         busy_r <= 1'b0;
      end
   end

   // Remembers an acknowledge since the last start, for the stop flag.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ackSeen_r <= 1'b0;
      end else if (startDet || stopDet || !pe) begin
         ackSeen_r <= 1'b0;
      end else if (evt.ackDone) begin
         ackSeen_r <= 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // Status register A flags.
   // ------------------------------------------------------------------
   // Post-address event: pending until status A read then control write.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         addrEvt_r <= 1'b0;
      end else if (!pe) begin
         addrEvt_r <= 1'b0;
      end else if (evt.addrSent) begin
         addrEvt_r <= 1'b1;
      end else if (marker_r && wrCtl) begin
         addrEvt_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         btfHeld_r <= 1'b0;
      end else if (!pe) begin
         btfHeld_r <= 1'b0;
      end else if (evt.byteTx && (addrEvt_r || evt.addrSent)) begin
         btfHeld_r <= 1'b1;
      end else if (!addrEvt_r) begin
         btfHeld_r <= 1'b0;
      end
   end

   assign setTra = pe & ((evt.byteTx & ~addrEvt_r & ~evt.addrSent) | (btfHeld_r & ~addrEvt_r));
   assign setBtf = setTra | (pe & evt.byteRx & ctl_r[isf_pkg::CT_ACK]);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         btf_r <= 1'b0;
      end else if (!pe) begin
         btf_r <= 1'b0;
      end else if (setBtf) begin
         btf_r <= 1'b1;
      end else if (marker_r && ((tra_r && wrData) || (!tra_r && rdData))) begin
         btf_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tra_r <= 1'b0;
      end else if (!pe || stopDet || evt.arbLost) begin
         tra_r <= 1'b0;
      end else if (setBtf) begin
         tra_r <= setTra;
      end else if (!btf_r) begin
         tra_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         addr_match_flag_r <= 1'b0;
      end else if (!pe) begin
         addr_match_flag_r <= 1'b0;
      end else if (!msl_r && (evt.addrMatch ||
                              (evt.genCall && ctl_r[isf_pkg::CT_GCEN]))) begin
         addr_match_flag_r <= 1'b1;
      end else if (rdA) begin
         addr_match_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         msl_r <= 1'b0;
      end else if (!pe || stopDet || evt.arbLost) begin
         msl_r <= 1'b0;
      end else if (wrCtl && writedata[isf_pkg::CT_START] && writedata[isf_pkg::CT_ON]) begin
         msl_r <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sb_r <= 1'b0;
      end else if (!pe) begin
         sb_r <= 1'b0;
      end else if (evt.startSent) begin
         sb_r <= 1'b1;
      end else if (marker_r && wrData) begin
         sb_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Status register B flags, all but general call cleared by a status B read.
   // ------------------------------------------------------------------
   // error flags
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         af_r    <= 1'b0;
         stop_seen_flag_r <= 1'b0;
         arb_lost_flag_r  <= 1'b0;
         bus_error_flag_r  <= 1'b0;
      end else if (!pe) begin
         af_r    <= 1'b0;
         stop_seen_flag_r <= 1'b0;
         arb_lost_flag_r  <= 1'b0;
         bus_error_flag_r  <= 1'b0;
      end else begin
         af_r    <= evt.ackFail | (af_r & ~rdB);
         stop_seen_flag_r <= (stopDet & ~msl_r & ctl_r[isf_pkg::CT_ACK] & ackSeen_r) |
                    (stop_seen_flag_r & ~rdB);
         arb_lost_flag_r  <= evt.arbLost | (arb_lost_flag_r & ~rdB);
         bus_error_flag_r  <= evt.busErr | (bus_error_flag_r & ~rdB);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         gen_call_flag_r <= 1'b0;
      end else if (!pe) begin
         gen_call_flag_r <= 1'b0;
      end else if (evt.genCall && ctl_r[isf_pkg::CT_GCEN]) begin
         gen_call_flag_r <= 1'b1;
      end else if (stopDet) begin
         gen_call_flag_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Event flag.
   // ------------------------------------------------------------------
   // event flag
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         evf_r <= 1'b0;
      end else if (!pe) begin
         evf_r <= 1'b0;
      end else if (setBtf || evt.addrMatch || evt.startSent || evt.addrSent ||
                   (!msl_r && evt.genCall && ctl_r[isf_pkg::CT_GCEN]) ||
                   evt.ackFail || evt.arbLost || evt.busErr ||
                   (stopDet && !msl_r && ctl_r[isf_pkg::CT_ACK] && ackSeen_r)) begin
         evf_r <= 1'b1;
      end else if (rdB || (rdA && addr_match_flag_r) || seqData || (marker_r && wrCtl)) begin
         evf_r <= 1'b0;
      end
   end

   assign statA = {evf_r, 1'b0, tra_r, busy_r, btf_r, addr_match_flag_r, msl_r, sb_r};
   assign statB = {3'h0, af_r, stop_seen_flag_r, arb_lost_flag_r, bus_error_flag_r, gen_call_flag_r};

   // ------------------------------------------------------------------
   // Clock stretch and interrupt.
   // ------------------------------------------------------------------
   assign errAny = af_r | stop_seen_flag_r | arb_lost_flag_r | bus_error_flag_r;

   assign sclOe_n = ~(pe & (btf_r | addr_match_flag_r | sb_r | addrEvt_r) & ~errAny);
   assign sclOut  = 1'b0;

   assign irq = evf_r & ctl_r[isf_pkg::CT_IRQEN] & ~globalMask;

   // ------------------------------------------------------------------
   // Assertions.
   // ------------------------------------------------------------------
   sequence sReadA;
      rdA;
   endsequence
   sequence sDataRead;
      rdData && !tra_r && !setBtf && pe;
   endsequence

   AST_RESERVED: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (read && !ackCycle_r && (hitA || hitB)) |=> (readdata[31:8] == 24'h0 &&
      (hitA ? readdata[6] == 1'b0 : readdata[7:5] == 3'h0)))
      else $error("reserved status bits read non-zero");
   AST_OFF_CLEARS: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!pe && !wrCtl) |=> (statA[7:5] == 3'h0 && statA[3:0] == 4'h0 && statB == 8'h00))
      else $error("flags not cleared while interface off");
   AST_BYTE_STRETCH: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (pe && btf_r && !errAny) |-> !sclOe_n)
      else $error("clock not held low while byte done");
   AST_NO_STRETCH_ERR: assert property (@(posedge clk_sys) disable iff (!rst_n)
      errAny |-> sclOe_n)
      else $error("clock held low with an error flag set");
   AST_BUSY_START: assert property (@(posedge clk_sys) disable iff (!rst_n)
      startDet |=> busy_r)
      else $error("busy not set after start");
   AST_BUSY_STOP: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (stopDet && !startDet) |=> !busy_r)
      else $error("busy not cleared after stop");
   AST_ARB_SLAVE: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (evt.arbLost && pe && !wrCtl) |=> (arb_lost_flag_r && !msl_r && !tra_r))
      else $error("arbitration loss not flagged or still master");
   AST_B_READ_CLEAR: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (rdB && !evt.ackFail) |=> !af_r)
      else $error("ack failure not cleared by status B read");
   AST_SEQ_RX_CLEAR: assert property (@(posedge clk_sys) disable iff (!rst_n)
      sReadA ##1 (!acc)[*2] ##1 sDataRead |=> !btf_r)
      else $error("byte done not cleared by read sequence");
   AST_IRQ: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (evf_r && ctl_r[isf_pkg::CT_IRQEN]) |-> (irq == !globalMask))
      else $error("interrupt not following event flag");

endmodule

`default_nettype wire

//--- isf_pkg.sv
// Purpose: Shared constants and types for the two-wire status flag block.
// Assumes: Avalon-MM slave with 32-bit data, byte addresses, one word per register.
// Notes:   Offsets, bit positions and reset values live here only.
package isf_pkg;
   // ------------------------------------------------------------------
   // Register map (byte addresses).
   // ------------------------------------------------------------------
   localparam logic [3:0] OFS_STATUS_PRIMARY = 4'h0;
   localparam logic [3:0] OFS_STATUS_ERRORS  = 4'h4;
   localparam logic [3:0] OFS_CONTROL        = 4'h8;
   localparam logic [3:0] OFS_DATA           = 4'hc;

   // ------------------------------------------------------------------
   // Field positions of status_reg_a.
   // ------------------------------------------------------------------
   localparam int SA_EVENT    = 7;
   localparam int SA_SENT     = 5;
   localparam int SA_BUSY     = 4;
   localparam int SA_BYTEDONE = 3;
   localparam int SA_ADDRMAT  = 2;
   localparam int SA_MASTER   = 1;
   localparam int SA_START    = 0;

   // ------------------------------------------------------------------
   // Field positions of status_reg_b.
   // ------------------------------------------------------------------
   localparam int SB_ACKFAIL  = 4;
   localparam int SB_STOP     = 3;
   localparam int SB_ARBLOST  = 2;
   localparam int SB_BUSERR   = 1;
   localparam int SB_GENCALL  = 0;

   // ------------------------------------------------------------------
   // Field positions of the control register and reset values.
   // ------------------------------------------------------------------
   localparam int CT_ON       = 5;
   localparam int CT_GCEN     = 4;
   localparam int CT_START    = 3;
   localparam int CT_ACK      = 2;
   localparam int CT_IRQEN    = 0;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   // Event pulses from the bit-level engine, same clock as this block.
   typedef struct packed {
      logic byteTx;      // Transmitted byte, acknowledge clock pulse received.
      logic byteRx;      // Received byte, acknowledge clock pulse sent.
      logic addrMatch;   // Own address received in slave mode.
      logic genCall;     // General call address received.
      logic startSent;   // Requested start condition generated.
      logic addrSent;    // Address byte sent in master mode.
      logic ackDone;     // An acknowledge bit passed on the bus.
      logic ackFail;     // No acknowledge for a byte.
      logic arbLost;     // Arbitration lost to another master.
      logic busErr;      // Misplaced start or stop condition.
   } isf_evt_t;

   // Control bits handed to the bit-level engine.
   typedef struct packed {
      logic on;
      logic genCallEn;
      logic startReq;
      logic ackEn;
      logic irqEn;
   } isf_ctl_t;
endpackage

//--- isf_bus_partner.sv
// Purpose: Far-side party on the two-wire bus that frames start and stop conditions.
// Assumes: Both lines are open-drain with pull-ups; link half period is 100 ns.
// Notes:   Lines stand still outside frames; the block may pull the clock line low.
`timescale 1ns/10ps
`default_nettype none
module isf_bus_partner (
   input  wire logic sclOe_n,
   output logic      sclLine,
   output logic      sdaLine
);
   logic sclDrv;
   logic sdaDrv;

   // Wired AND of both parties on the clock line; the pull-up wins when everyone releases.
   assign sclLine = sclDrv & sclOe_n;
   assign sdaLine = sdaDrv;

   // Idle bus: both lines released.
   initial begin
      sclDrv = 1'b1;
      sdaDrv = 1'b1;
   end

   task automatic busStart();
      #3;
      sdaDrv = 1'b0;
      #100;
      sclDrv = 1'b0;
      #100;
   endtask

   task automatic busStop();
      #3;
      sdaDrv = 1'b0;
      #100;
      sclDrv = 1'b1;
      #100;
      sdaDrv = 1'b1;
      #100;
   endtask
endmodule
`default_nettype wire

//--- isf_status_flags_tb.sv
// Purpose: Self-checking bench for the status flag block over its register bus.
// Assumes: Engine events are one-cycle pulses driven by the bench.
// Notes:   Each test is a sequence of bus accesses with expected register values.
`timescale 1ns/10ps
`default_nettype none
module isf_status_flags_tb;
   localparam logic [3:0] SA = isf_pkg::OFS_STATUS_PRIMARY;
   localparam logic [3:0] SB = isf_pkg::OFS_STATUS_ERRORS;
   localparam logic [3:0] CT = isf_pkg::OFS_CONTROL;
   localparam logic [3:0] SD = isf_pkg::OFS_DATA;
   logic                clk_sys = 1'b0;
   logic                rst_n = 1'b0;
   logic [3:0]          address = 4'h0;
   logic                read = 1'b0;
   logic                write = 1'b0;
   logic [31:0]         writedata = 32'h0;
   logic [3:0]          byteenable = 4'hf;
   logic [31:0]         readdata, rd;
   logic                waitrequest, sclOut, sclOe_n, sclLine, sdaLine;
   logic                txLoad, rxTaken, irq;
   logic                globalMask = 1'b0;
   logic [7:0]          rxByte = 8'h5a;
   logic [7:0]          txByte;
   isf_pkg::isf_evt_t   evt = '0;
   isf_pkg::isf_ctl_t   ctl;
   int                  fails = 0;
   int                  check_count = 0;
   int                  loads = 0;
   int                  takes = 0;

   isf_status_flags DUT (
      .clk_sys(clk_sys), .rst_n(rst_n), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .evt(evt), .rxByte(rxByte), .ctl(ctl), .txByte(txByte),
      .txLoad(txLoad), .rxTaken(rxTaken), .sclIn(sclLine), .sdaIn(sdaLine), .sclOut(sclOut),
      .sclOe_n(sclOe_n), .globalMask(globalMask), .irq(irq));
   isf_bus_partner PEER (.sclOe_n(sclOe_n), .sclLine(sclLine), .sdaLine(sdaLine));

   // System clock of 25 ns.
   always #12.5 clk_sys = ~clk_sys;

   // Counts the load and take strobes toward the engine.
   always @(posedge clk_sys) begin
      loads <= loads + txLoad;
      takes <= takes + rxTaken;
   end

   // Compares one value and counts the outcome.
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask

   // One bus access, held until waitrequest is seen low.
   task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      address <= a;
      writedata <= {24'h0, d};
      read <= !w;
      write <= w;
      @(posedge clk_sys);
      while (waitrequest !== 1'b0) @(posedge clk_sys);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic rdChk(input string n, input logic [3:0] a, input logic [7:0] e);
      acc(1'b0, a, 8'h00);
      chk(n, {24'h0, e}, rd);
   endtask

   // Drives one engine event for one cycle.
   task automatic pulse(input isf_pkg::isf_evt_t e);
      @(posedge clk_sys);
      evt <= e;
      @(posedge clk_sys);
      evt <= '0;
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Cuts a hung run short.
   initial begin
      #200000;
      fails++;
      final_report();
   end

   // Main test sequence.
   initial begin
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      rdChk("statusA", SA, 8'h00);
      rdChk("statusB", SB, 8'h00);
      rdChk("unmapped", 4'h2, 8'h00);
      PEER.busStart();
      repeat (4) @(posedge clk_sys);
      rdChk("busyOff", SA, 8'h10);
      PEER.busStop();
      repeat (4) @(posedge clk_sys);
      rdChk("idle", SA, 8'h00);
      $display("test busy done");
      acc(1'b1, CT, 8'h25);
      pulse(10'h080);
      @(posedge clk_sys);
      chk("sclOe_n", 32'h0, sclOe_n);
      chk("irq", 32'h1, irq);
      globalMask <= 1'b1;
      @(posedge clk_sys);
      chk("irqMasked", 32'h0, irq);
      globalMask <= 1'b0;
      rdChk("addr_match_flag", SA, 8'h84);
      rdChk("adslClr", SA, 8'h00);
      $display("test address done");
      pulse(10'h100);
      rdChk("rxDone", SA, 8'h88);
      chk("stretch", 32'h0, sclOe_n);
      rdChk("rxData", SD, 8'h5a);
      rdChk("rxClr", SA, 8'h00);
      pulse(10'h200);
      rdChk("txDone", SA, 8'ha8);
      acc(1'b1, SD, 8'hc3);
      rdChk("txClr", SA, 8'h00);
      chk("txByte", 32'hc3, txByte);
      $display("test bytes done");
      pulse(10'h104);
      rdChk("evfErr", SA, 8'h88);
      chk("noStretch", 32'h1, sclOe_n);
      rdChk("ackFail", SB, 8'h10);
      rdChk("errClr", SA, 8'h08);
      rdChk("rxData2", SD, 8'h5a);
      acc(1'b1, CT, 8'h2d);
      rdChk("master", SA, 8'h02);
      pulse(10'h020);
      rdChk("startA", SA, 8'h83);
      chk("startHold", 32'h0, sclOe_n);
      chk("sclOut", 32'h0, sclOut);
      chk("startReq", 32'h0, ctl.startReq);
      acc(1'b1, SD, 8'ha0);
      pulse(10'h010);
      pulse(10'h200);
      rdChk("addrSent", SA, 8'h82);
      chk("addrHold", 32'h0, sclOe_n);
      acc(1'b1, CT, 8'h25);
      rdChk("txAfterAddr", SA, 8'haa);
      acc(1'b1, SD, 8'h11);
      rdChk("addrDone", SA, 8'h02);
      pulse(10'h002);
      rdChk("arbA", SA, 8'h80);
      rdChk("arbB", SB, 8'h04);
      $display("test errors done");
      pulse(10'h001);
      rdChk("berrA", SA, 8'h80);
      acc(1'b1, CT, 8'h00);
      rdChk("offB", SB, 8'h00);
      rdChk("offA", SA, 8'h00);
      $display("test disable done");
      acc(1'b1, CT, 8'h35);
      PEER.busStart();
      pulse(10'h048);
      rdChk("gcA", SA, 8'h94);
      rdChk("gcB", SB, 8'h01);
      PEER.busStop();
      repeat (4) @(posedge clk_sys);
      rdChk("stopB", SB, 8'h08);
      rdChk("stopA", SA, 8'h00);
      chk("txLoads", 32'h3, loads);
      chk("rxTakes", 32'h2, takes);
      $display("test slave done");
      final_report();
   end
endmodule
`default_nettype wire
